// *** logic/rsc_divider.sv ***
// sequential unsigned divider used for segment interpolation
`timescale 1ns/100ps
module rsc_divider (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [13:0] num,
    input wire logic [7:0] den,
    output logic done,
    output logic [13:0] quot
);
    typedef struct packed {
        logic busy;
        logic done;
        logic [3:0] cnt;
        logic [8:0] rem;
        logic [13:0] quo;
    } rsc_div_s;

    rsc_div_s q;
    rsc_div_s d;
    logic [8:0] trial;

    // den must stay stable from start until done; the caller holds it in a register
    always_comb begin
        d = q;
        d.done = 1'b0;
        trial = {q.rem[7:0], q.quo[13]};
        if (rst) begin
            d = '0;
        end else if (start) begin
            d.busy = 1'b1;
            d.cnt = rsc_pkg::DIV_STEPS;
            d.rem = 9'h000;
            d.quo = num;
        end else if (q.busy) begin
            d.quo = {q.quo[12:0], 1'b0};
            if (trial >= {1'b0, den}) begin
                d.rem = trial - {1'b0, den};
                d.quo[0] = 1'b1;
            end else begin
                d.rem = trial;
            end
            d.cnt = q.cnt - 4'h1;
            if (q.cnt == rsc_pkg::DIV_LAST) begin
                d.busy = 1'b0;
                d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    assign done = q.done;
    assign quot = q.quo;
endmodule

// *** logic/rsc_pkg.sv ***
// shared constants for the rail setpoint and common-electrode compensation block
package rsc_pkg;
    // register byte offsets on the wishbone slave
    localparam logic [7:0] OFS_RAIL_POS = 8'h00;
    localparam logic [7:0] OFS_GATE_ON = 8'h04;
    localparam logic [7:0] OFS_GATE_OFF = 8'h08;
    localparam logic [7:0] OFS_DELAY_LSB = 8'h0C;
    localparam logic [7:0] OFS_SP_ROOM = 8'h10;
    localparam logic [7:0] OFS_DELTA_LOW = 8'h14;
    localparam logic [7:0] OFS_DELTA_H1 = 8'h18;
    localparam logic [7:0] OFS_DELTA_H2 = 8'h1C;
    localparam logic [7:0] OFS_TB_ROOM = 8'h20;
    localparam logic [7:0] OFS_TB_LOW = 8'h24;
    localparam logic [7:0] OFS_TB_H1 = 8'h28;
    localparam logic [7:0] OFS_TB_H2 = 8'h2C;
    localparam logic [7:0] OFS_LIM_LO = 8'h30;
    localparam logic [7:0] OFS_LIM_HI = 8'h34;
    localparam logic [7:0] OFS_TEMP = 8'h38;
    localparam logic [7:0] OFS_COMMON = 8'h3C;
    // field positions
    localparam int CODE_MSB = 5;
    localparam int PUMP_BIT = 6;
    localparam int COMP_EN_BIT = 1;
    localparam int SP_LSB_BIT = 0;
    localparam int DELAY_LSB_POS = 2;
    localparam int DELTA_MSB = 4;
    // reset values
    localparam logic [5:0] RST_RAIL_POS = 6'h00;
    localparam logic [5:0] RST_GATE_ON = 6'h00;
    localparam logic [5:0] RST_GATE_OFF = 6'h16;
    localparam logic [7:0] RST_SP_ROOM = 8'h00;
    localparam logic [7:0] RST_LIM_LO = 8'h00;
    localparam logic [7:0] RST_LIM_HI = 8'hFF;
    // one code step of the common-electrode output, in microvolts
    localparam int COMMON_STEP_UV = 6830;
    // restoring divider: one quotient bit per cycle
    localparam logic [3:0] DIV_STEPS = 4'hE;
    localparam logic [3:0] DIV_LAST = 4'h1;
    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_WAIT} rsc_state_e;
endpackage

// *** logic/rsc_setpoint_top.sv ***
// rail setpoint registers and temperature-compensated common-electrode code
//
// Functional notes
// - positive rail level from 6-bit code
// - negative rail mirrors positive rail code
// - gate-on rail code in bits 5:0
// - gate-off rail code in bits 5:0
// - one common code step is 6.83mV
// - 9-bit room setpoint, lsb from delay register
// - low and first-high deltas signed, from setpoint
// - second-high delta relative to first-high value
// - breakpoint values exact, linear interpolation between
// - compensation only when enable bit set
// - clamp result between lower and upper limits
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/100ps
module rsc_setpoint_top (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [7:0] ADC_RESULT,
    input wire logic ADC_VALID,
    output logic [5:0] POS_RAIL_CODE,
    output logic [5:0] NEG_RAIL_CODE,
    output logic [5:0] GATE_ON_CODE,
    output logic [5:0] GATE_OFF_CODE,
    output logic PUMP_TWO_STAGE_SELECT,
    output logic [8:0] COMMON_CODE
);
    typedef struct packed {
        logic [5:0] rail_pos;
        logic [5:0] rail_neg;
        logic [5:0] gate_on;
        logic pump_two_stage_select;
        logic [5:0] gate_off;
        logic [5:0] delays;
        logic compensation_enable;
        logic common_setpoint_room_lsb;
        logic [7:0] common_setpoint_room_upper;
        logic [4:0] common_delta_low;
        logic [4:0] common_delta_high_first;
        logic [4:0] common_delta_high_second;
        logic [7:0] temp_breakpoint_room;
        logic [7:0] temp_breakpoint_low;
        logic [7:0] temp_breakpoint_high_first;
        logic [7:0] temp_breakpoint_high_second;
        logic [7:0] common_lower_limit;
        logic [7:0] common_upper_limit;
        logic [7:0] temp;
        logic pend;
        rsc_pkg::rsc_state_e st;
        logic signed [11:0] base;
        logic neg;
        logic [13:0] num;
        logic [7:0] den;
        logic start;
        logic [8:0] comp;
        logic [8:0] common;
        logic ack;
        logic [31:0] dat;
    } rsc_core_s;

    rsc_core_s q;
    rsc_core_s d;
    logic div_done;
    logic [13:0] div_quot;

    function automatic logic signed [11:0] sext5(input logic [4:0] v);
        sext5 = {{7{v[4]}}, v};
    endfunction

    // limits are 8-bit, so they bound the upper eight bits of the 9-bit code
    function automatic logic [8:0] clamp(input logic signed [11:0] v,
                                         input logic [7:0] lo, input logic [7:0] hi);
        logic signed [11:0] lo_s;
        logic signed [11:0] hi_s;
        lo_s = {3'b000, lo, 1'b0};
        hi_s = {3'b000, hi, 1'b1};
        if (v > hi_s) begin
            clamp = hi_s[8:0];
        end else if (v < lo_s) begin
            clamp = lo_s[8:0];
        end else begin
            clamp = v[8:0];
        end
    endfunction

    rsc_divider u_div (
        .clk(CLK_SYS),
        .rst(RST),
        .start(q.start),
        .num(q.num),
        .den(q.den),
        .done(div_done),
        .quot(div_quot)
    );

    logic signed [11:0] v_room;
    logic signed [11:0] v_low;
    logic signed [11:0] v_h1;
    logic signed [11:0] v_h2;
    logic signed [11:0] v0;
    logic signed [11:0] v1;
    logic signed [11:0] dv;
    logic signed [11:0] res;
    logic [7:0] t0;
    logic [7:0] t1;
    logic hold;
    logic [5:0] mag;
    logic [7:0] dt;
    logic [31:0] rdat;
    logic wr;

    always_comb begin
        // 12-bit signed holds setpoint plus two stacked deltas with margin
        v_room = {3'b000, q.common_setpoint_room_upper, q.common_setpoint_room_lsb};
        v_low = v_room + sext5(q.common_delta_low);
        v_h1 = v_room + sext5(q.common_delta_high_first);
        v_h2 = v_h1 + sext5(q.common_delta_high_second);
        hold = 1'b0;
        t0 = q.temp_breakpoint_low;
        t1 = q.temp_breakpoint_room;
        v0 = v_low;
        v1 = v_room;
        // breakpoints ascend with the ADC result: low, room, first high, second high
        if (q.temp <= q.temp_breakpoint_low) begin
            hold = 1'b1;
        end else if (q.temp < q.temp_breakpoint_room) begin
            t0 = q.temp_breakpoint_low;
        end else if (q.temp < q.temp_breakpoint_high_first) begin
            t0 = q.temp_breakpoint_room;
            t1 = q.temp_breakpoint_high_first;
            v0 = v_room;
            v1 = v_h1;
        end else if (q.temp < q.temp_breakpoint_high_second) begin
            t0 = q.temp_breakpoint_high_first;
            t1 = q.temp_breakpoint_high_second;
            v0 = v_h1;
            v1 = v_h2;
        end else begin
            hold = 1'b1;
            v0 = v_h2;
        end
        dv = v1 - v0;
        // a full negative delta gives a slope of 16 steps, one more than five bits hold
        mag = dv[11] ? 6'(-dv) : dv[5:0];
        dt = q.temp - t0;
        res = q.neg ? q.base - {2'b00, div_quot[9:0]} : q.base + {2'b00, div_quot[9:0]};
    end

    always_comb begin
        rdat = 32'h0000_0000;
        unique case (WB_ADR_I)
            rsc_pkg::OFS_RAIL_POS: rdat[5:0] = q.rail_pos;
            rsc_pkg::OFS_GATE_ON: rdat[6:0] = {q.pump_two_stage_select, q.gate_on};
            rsc_pkg::OFS_GATE_OFF: rdat[5:0] = q.gate_off;
            rsc_pkg::OFS_DELAY_LSB: rdat[7:0] = {q.delays, q.compensation_enable,
                                                 q.common_setpoint_room_lsb};
            rsc_pkg::OFS_SP_ROOM: rdat[7:0] = q.common_setpoint_room_upper;
            rsc_pkg::OFS_DELTA_LOW: rdat[4:0] = q.common_delta_low;
            rsc_pkg::OFS_DELTA_H1: rdat[4:0] = q.common_delta_high_first;
            rsc_pkg::OFS_DELTA_H2: rdat[4:0] = q.common_delta_high_second;
            rsc_pkg::OFS_TB_ROOM: rdat[7:0] = q.temp_breakpoint_room;
            rsc_pkg::OFS_TB_LOW: rdat[7:0] = q.temp_breakpoint_low;
            rsc_pkg::OFS_TB_H1: rdat[7:0] = q.temp_breakpoint_high_first;
            rsc_pkg::OFS_TB_H2: rdat[7:0] = q.temp_breakpoint_high_second;
            rsc_pkg::OFS_LIM_LO: rdat[7:0] = q.common_lower_limit;
            rsc_pkg::OFS_LIM_HI: rdat[7:0] = q.common_upper_limit;
            rsc_pkg::OFS_TEMP: rdat[7:0] = q.temp;
            rsc_pkg::OFS_COMMON: rdat[8:0] = q.common;
            default: rdat = 32'h0000_0000;
        endcase
    end

    always_comb begin
        d = q;
        d.start = 1'b0;
        // ack one cycle after the request, and the write lands on the edge that samples ack
        d.ack = WB_CYC_I && WB_STB_I && !q.ack;
        d.dat = d.ack ? rdat : 32'h0000_0000;
        wr = WB_CYC_I && WB_STB_I && WB_WE_I && q.ack && WB_SEL_I[0];
        if (wr) begin
            unique case (WB_ADR_I)
                rsc_pkg::OFS_RAIL_POS: d.rail_pos = WB_DAT_I[rsc_pkg::CODE_MSB:0];
                rsc_pkg::OFS_GATE_ON: begin
                    d.gate_on = WB_DAT_I[rsc_pkg::CODE_MSB:0];
                    d.pump_two_stage_select = WB_DAT_I[rsc_pkg::PUMP_BIT];
                end
                rsc_pkg::OFS_GATE_OFF: d.gate_off = WB_DAT_I[rsc_pkg::CODE_MSB:0];
                rsc_pkg::OFS_DELAY_LSB: begin
                    d.delays = WB_DAT_I[7:rsc_pkg::DELAY_LSB_POS];
                    d.compensation_enable = WB_DAT_I[rsc_pkg::COMP_EN_BIT];
                    d.common_setpoint_room_lsb = WB_DAT_I[rsc_pkg::SP_LSB_BIT];
                end
                rsc_pkg::OFS_SP_ROOM: d.common_setpoint_room_upper = WB_DAT_I[7:0];
                rsc_pkg::OFS_DELTA_LOW: d.common_delta_low = WB_DAT_I[rsc_pkg::DELTA_MSB:0];
                rsc_pkg::OFS_DELTA_H1:
                    d.common_delta_high_first = WB_DAT_I[rsc_pkg::DELTA_MSB:0];
                rsc_pkg::OFS_DELTA_H2:
                    d.common_delta_high_second = WB_DAT_I[rsc_pkg::DELTA_MSB:0];
                rsc_pkg::OFS_TB_ROOM: d.temp_breakpoint_room = WB_DAT_I[7:0];
                rsc_pkg::OFS_TB_LOW: d.temp_breakpoint_low = WB_DAT_I[7:0];
                rsc_pkg::OFS_TB_H1: d.temp_breakpoint_high_first = WB_DAT_I[7:0];
                rsc_pkg::OFS_TB_H2: d.temp_breakpoint_high_second = WB_DAT_I[7:0];
                rsc_pkg::OFS_LIM_LO: d.common_lower_limit = WB_DAT_I[7:0];
                rsc_pkg::OFS_LIM_HI: d.common_upper_limit = WB_DAT_I[7:0];
                default: d.rail_pos = q.rail_pos;
            endcase
        end
        d.rail_neg = d.rail_pos;
        // newest sample wins; a result arriving mid-calculation is run next
        if (ADC_VALID) begin
            d.temp = ADC_RESULT;
            d.pend = 1'b1;
        end
        unique case (q.st)
            rsc_pkg::ST_IDLE: begin
                if (q.pend && !ADC_VALID) begin
                    d.pend = 1'b0;
                    d.st = rsc_pkg::ST_SETUP;
                end
            end
            rsc_pkg::ST_SETUP: begin
                if (hold) begin
                    d.comp = clamp(v0, q.common_lower_limit, q.common_upper_limit);
                    d.st = rsc_pkg::ST_IDLE;
                end else begin
                    // one code step (6.83mV) resolution: quotient truncates to whole steps
                    d.base = v0;
                    d.neg = dv[11];
                    d.num = 14'(mag) * 14'(dt);
                    d.den = t1 - t0;
                    d.start = 1'b1;
                    d.st = rsc_pkg::ST_WAIT;
                end
            end
            rsc_pkg::ST_WAIT: begin
                if (div_done) begin
                    d.comp = clamp(res, q.common_lower_limit, q.common_upper_limit);
                    d.st = rsc_pkg::ST_IDLE;
                end
            end
            default: d.st = rsc_pkg::ST_IDLE;
        endcase
        d.common = q.compensation_enable ? q.comp
            : clamp(v_room, q.common_lower_limit, q.common_upper_limit);
        if (RST) begin
            d = '0;
            d.rail_pos = rsc_pkg::RST_RAIL_POS;
            d.rail_neg = rsc_pkg::RST_RAIL_POS;
            d.gate_on = rsc_pkg::RST_GATE_ON;
            d.gate_off = rsc_pkg::RST_GATE_OFF;
            d.common_setpoint_room_upper = rsc_pkg::RST_SP_ROOM;
            d.common_lower_limit = rsc_pkg::RST_LIM_LO;
            d.common_upper_limit = rsc_pkg::RST_LIM_HI;
            d.st = rsc_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        q <= d;
    end

    assign WB_DAT_O = q.dat;
    assign WB_ACK_O = q.ack;
    assign POS_RAIL_CODE = q.rail_pos;
    assign NEG_RAIL_CODE = q.rail_neg;
    assign GATE_ON_CODE = q.gate_on;
    assign GATE_OFF_CODE = q.gate_off;
    assign PUMP_TWO_STAGE_SELECT = q.pump_two_stage_select;
    assign COMMON_CODE = q.common;
endmodule

// *** test/rsc_host_model.sv ***
// wishbone host and temperature result source for the setpoint block
`timescale 1ns/100ps
module rsc_host_model (
    input wire logic clk,
    input wire logic ack,
    input wire logic [31:0] dat_in,
    output logic cyc,
    output logic stb,
    output logic we,
    output logic [7:0] adr,
    output logic [3:0] sel,
    output logic [31:0] dat_out,
    output logic [7:0] adc_res,
    output logic adc_vld
);
    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        dat_out = 32'h0000_0000;
        adc_res = 8'h00;
        adc_vld = 1'b0;
    end
    // one classic cycle; the request holds until ack is seen high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat_out <= d;
        @(posedge clk);
        while (ack !== 1'b1) begin
            @(posedge clk);
        end
        q = dat_in;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        // released data lines must not keep looking valid
        dat_out <= ~d;
    endtask
    task automatic adc(input logic [7:0] t);
        @(posedge clk);
        adc_res <= t;
        adc_vld <= 1'b1;
        @(posedge clk);
        adc_vld <= 1'b0;
        adc_res <= ~t;
    endtask
endmodule

// *** test/rsc_setpoint_top_monitor.sv ***
// port-level assertions for the rail setpoint block
`timescale 1ns/100ps
module rsc_setpoint_monitor (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic [7:0] ADC_RESULT,
    input wire logic ADC_VALID,
    input wire logic [5:0] POS_RAIL_CODE,
    input wire logic [5:0] NEG_RAIL_CODE,
    input wire logic [5:0] GATE_ON_CODE,
    input wire logic [5:0] GATE_OFF_CODE,
    input wire logic PUMP_TWO_STAGE_SELECT,
    input wire logic [8:0] COMMON_CODE
);
    // cycles since the last event that may move the common code
    logic [4:0] quiet_q;
    always_ff @(posedge CLK_SYS) begin
        if (RST || ADC_VALID || (WB_ACK_O && WB_WE_I)) begin
            quiet_q <= 5'h00;
        end else if (quiet_q != 5'h1F) begin
            quiet_q <= quiet_q + 5'h01;
        end
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    property p_wr(logic [7:0] ofs, logic [5:0] code);
        WB_ACK_O && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == ofs |=> code == $past(WB_DAT_I[5:0]);
    endproperty
    AST_NEG_MIRROR: assert property (NEG_RAIL_CODE == POS_RAIL_CODE)
        else $error("negative rail code differs from positive");
    AST_ACK_PULSE: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("ack not a single pulse one cycle after request");
    AST_DAT_IDLE: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0000_0000)
        else $error("read data not zero outside ack");
    AST_POS_SET: assert property (p_wr(rsc_pkg::OFS_RAIL_POS, POS_RAIL_CODE))
        else $error("positive rail code not taken from write");
    AST_GATE_ON_SET: assert property (p_wr(rsc_pkg::OFS_GATE_ON, GATE_ON_CODE))
        else $error("gate-on code not taken from write");
    AST_GATE_OFF_SET: assert property (p_wr(rsc_pkg::OFS_GATE_OFF, GATE_OFF_CODE))
        else $error("gate-off code not taken from write");
    AST_RESET_OUT: assert property ($fell(RST) |-> GATE_OFF_CODE == 6'h16 && POS_RAIL_CODE == 6'h00
        && !WB_ACK_O && COMMON_CODE == 9'h000)
        else $error("outputs not at reset values after release");
    AST_CODE_QUIET: assert property ($changed(COMMON_CODE) |-> quiet_q < 5'h1A)
        else $error("common code moved without a result or write");
    COV_ADC: cover property (ADC_VALID);
    COV_CODE: cover property ($changed(COMMON_CODE));
    COV_READ: cover property (WB_ACK_O && !WB_WE_I);
endmodule

bind rsc_setpoint_top rsc_setpoint_monitor mon_u (
    .CLK_SYS(CLK_SYS), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .ADC_RESULT(ADC_RESULT), .ADC_VALID(ADC_VALID),
    .POS_RAIL_CODE(POS_RAIL_CODE), .NEG_RAIL_CODE(NEG_RAIL_CODE), .GATE_ON_CODE(GATE_ON_CODE),
    .GATE_OFF_CODE(GATE_OFF_CODE), .PUMP_TWO_STAGE_SELECT(PUMP_TWO_STAGE_SELECT),
    .COMMON_CODE(COMMON_CODE)
);

// *** test/tb_rail_setpoint_temp_compensation.sv ***
// self-checking bench for the rail setpoint and compensation block
`timescale 1ns/100ps
module tb_rail_setpoint_temp_compensation;
    logic clk;
    logic rst = 1'b1;
    logic cyc, stb, we, ack, adc_vld, pump;
    logic [7:0] adr, adc_res;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic [5:0] pos, neg, gon, goff;
    logic [8:0] common;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    // setpoint 0xDA, deltas -13/+3/+10, breakpoints 02/1F/66/CD
    logic [7:0] cfg [8] = '{8'h6D, 8'h13, 8'h03, 8'h0A, 8'h1F, 8'h02, 8'h66, 8'hCD};
    logic [7:0] temps [7] = '{8'h01, 8'h10, 8'h1F, 8'h66, 8'h99, 8'hCD, 8'hFF};
    logic [8:0] codes [7] = '{9'h0CD, 9'h0D3, 9'h0DA, 9'h0DD, 9'h0E1, 9'h0E7, 9'h0E7};
    rsc_setpoint_top dut_u (
        .CLK_SYS(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .ADC_RESULT(adc_res), .ADC_VALID(adc_vld), .POS_RAIL_CODE(pos), .NEG_RAIL_CODE(neg),
        .GATE_ON_CODE(gon), .GATE_OFF_CODE(goff), .PUMP_TWO_STAGE_SELECT(pump),
        .COMMON_CODE(common)
    );
    rsc_host_model host_u (
        .clk(clk), .ack(ack), .dat_in(rdat), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
        .sel(sel), .dat_out(wdat), .adc_res(adc_res), .adc_vld(adc_vld)
    );
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic conclude();
        if (num_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            conclude();
        end
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        host_u.xfer(1'b1, a, s, d, q);
    endtask
    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        host_u.xfer(1'b0, a, 4'hF, 32'h0000_0000, q);
        chk(name, q, exp);
    endtask
    // the result window is fixed by the hand-over latency bound
    task automatic tchk(input logic [7:0] t, input logic [8:0] exp);
        host_u.adc(t);
        repeat (25) @(posedge clk);
        chk("common_code", 32'(common), 32'(exp));
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rdchk("gate_off_reset", rsc_pkg::OFS_GATE_OFF, 32'h0000_0016);
        rdchk("upper_limit_reset", rsc_pkg::OFS_LIM_HI, 32'h0000_00FF);
        rdchk("unmapped", 8'h40, 32'h0000_0000);
        wr(rsc_pkg::OFS_RAIL_POS, 4'h1, 32'hFFFF_FFFF);
        rdchk("rail_pos_reg", rsc_pkg::OFS_RAIL_POS, 32'h0000_003F);
        chk("pos_rail", 32'(pos), 32'h0000_003F);
        chk("neg_rail", 32'(neg), 32'h0000_003F);
        wr(rsc_pkg::OFS_GATE_ON, 4'h1, 32'h0000_006A);
        rdchk("gate_on_reg", rsc_pkg::OFS_GATE_ON, 32'h0000_006A);
        wr(rsc_pkg::OFS_GATE_OFF, 4'hE, 32'h0000_003F);
        rdchk("gate_off_masked", rsc_pkg::OFS_GATE_OFF, 32'h0000_0016);
        wr(rsc_pkg::OFS_GATE_OFF, 4'h1, 32'h0000_0015);
        // the write lands on the ack edge, so the port shows it one edge later
        @(posedge clk);
        chk("gate_on", 32'(gon), 32'h0000_002A);
        chk("pump_select", 32'(pump), 32'h0000_0001);
        chk("gate_off", 32'(goff), 32'h0000_0015);
        for (int i = 0; i < 8; i++) begin
            wr(rsc_pkg::OFS_SP_ROOM + 8'(4 * i), 4'h1, 32'(cfg[i]));
        end
        wr(rsc_pkg::OFS_DELAY_LSB, 4'h1, 32'h0000_0002);
        rdchk("delay_reg", rsc_pkg::OFS_DELAY_LSB, 32'h0000_0002);
        for (int i = 0; i < 7; i++) begin
            tchk(temps[i], codes[i]);
        end
        rdchk("temp_reg", rsc_pkg::OFS_TEMP, 32'h0000_00FF);
        // falling last segment: truncation toward the first-high value
        wr(rsc_pkg::OFS_DELTA_H2, 4'h1, 32'h0000_0016);
        tchk(8'h99, 9'h0D9);
        host_u.adc(8'h01);
        tchk(8'hFF, 9'h0D3);
        wr(rsc_pkg::OFS_DELAY_LSB, 4'h1, 32'h0000_0001);
        repeat (3) @(posedge clk);
        chk("fixed_setpoint", 32'(common), 32'h0000_00DB);
        tchk(8'h01, 9'h0DB);
        rdchk("common_reg", rsc_pkg::OFS_COMMON, 32'h0000_00DB);
        wr(rsc_pkg::OFS_DELAY_LSB, 4'h1, 32'h0000_0002);
        wr(rsc_pkg::OFS_LIM_LO, 4'h1, 32'h0000_0067);
        wr(rsc_pkg::OFS_LIM_HI, 4'h1, 32'h0000_006D);
        tchk(8'h01, 9'h0CE);
        tchk(8'h66, 9'h0DB);
        rdchk("lower_limit", rsc_pkg::OFS_LIM_LO, 32'h0000_0067);
        // most negative low delta: a slope of 16 steps across the low segment
        wr(rsc_pkg::OFS_LIM_LO, 4'h1, 32'h0000_0000);
        wr(rsc_pkg::OFS_LIM_HI, 4'h1, 32'h0000_00FF);
        wr(rsc_pkg::OFS_DELTA_LOW, 4'h1, 32'h0000_0010);
        tchk(8'h10, 9'h0D1);
        conclude();
    end
endmodule
